/* logic/pcs_synth_ctrl.v */
// control face of the fractional-n clock synthesizer
// Behaviour
// - reference source pin or routing, configurable
// - feedback source routing or pin, configurable
// - feedback divider sets frequency multiplication
// - fractional multiplication with 16-bit resolution
// - each output owns an independent divider
// - output divide values 1 through 128
// - output dividers can be cascaded
// - outputs drive clock network or routing
// - lock rises on lock, falls on loss
// - secondary outputs take programmable phase shift
`timescale 1ns/1ps
module pcs_synth_ctrl (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // reference and feedback clock sources, asynchronous
  input wire i_ref_clk_pin,
  input wire i_ref_clk_route,
  input wire i_fb_clk_pin,
  input wire i_fb_clk_route,
  // source selection
  input wire i_ref_sel_route,
  input wire i_fb_sel_pin,
  // feedback multiplication, integer and fraction
  input wire [7:0] i_mult_int,
  input wire [15:0] i_mult_frac,
  // output dividers
  input wire [7:0] i_div_p,
  input wire [7:0] i_div_a,
  input wire [7:0] i_div_b,
  input wire [7:0] i_div_c,
  // cascade: secondary output n is fed by output n-1
  input wire [2:0] i_cascade,
  // phase offsets of secondary outputs in source ticks
  input wire [7:0] i_phase_a,
  input wire [7:0] i_phase_b,
  input wire [7:0] i_phase_c,
  // destination: 1 = clock network, 0 = general routing
  input wire [3:0] i_to_clk_net,
  // clock outputs, network copies
  output reg o_primary_clk_out,
  output reg o_secondary_clk_out_a,
  output reg o_secondary_clk_out_b,
  output reg o_secondary_clk_out_c,
  // clock outputs, general routing copies
  output reg [3:0] o_route_clk,
  // status
  output reg o_lock
);
`include "pcs_map.vh"
  // ---------------------------------------------
  // input synchronisers
  // ---------------------------------------------
  reg [3:0] sync1; // first stage, read only by sync2
  reg [3:0] sync2; // second stage
  reg ref_prev; // edge detect on selected reference
  reg fb_prev; // edge detect on selected feedback
  wire ref_now;
  wire fb_now;
  wire ref_edge;
  wire fb_edge;
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      ref_prev <= 1'b0;
      fb_prev <= 1'b0;
    end else begin
      sync1 <= {i_fb_clk_route, i_fb_clk_pin, i_ref_clk_route, i_ref_clk_pin};
      sync2 <= sync1;
      ref_prev <= ref_now;
      fb_prev <= fb_now;
    end
  end
  assign ref_now = i_ref_sel_route ? sync2[1] : sync2[0];
  assign fb_now = i_fb_sel_pin ? sync2[2] : sync2[3];
  assign ref_edge = ref_now & ~ref_prev;
  assign fb_edge = fb_now & ~fb_prev;
  // ---------------------------------------------
  // settings change detect
  // ---------------------------------------------
  // any change to divider settings drops lock and restarts the outputs
  reg [55:0] cfg_prev;
  wire [55:0] cfg_now;
  wire cfg_change;
  assign cfg_now = {i_mult_int, i_mult_frac, i_div_p, i_div_a, i_div_b, i_div_c};
  assign cfg_change = (cfg_now != cfg_prev);
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_prev <= 56'h0;
    end else begin
      cfg_prev <= cfg_now;
    end
  end
  // ---------------------------------------------
  // fractional-n synthesis tick generator
  // ---------------------------------------------
  // each reference edge adds mult_int (1 when zero) + frac/65536 ticks; ticks are spread
  // one per system clock, so the product must stay below the clock rate
  reg [15:0] frac_acc; // fractional phase accumulator
  reg [8:0] owed; // whole synthesized ticks still to emit
  reg vco_tick; // one synthesized tick
  wire [16:0] frac_sum;
  wire [7:0] mult_safe;
  assign frac_sum = {1'b0, frac_acc} + {1'b0, i_mult_frac};
  assign mult_safe = (i_mult_int == 8'h00) ? `PCS_MULT_RST : i_mult_int;
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      frac_acc <= 16'h0000;
      owed <= 9'h000;
      vco_tick <= 1'b0;
    end else if (cfg_change) begin
      frac_acc <= 16'h0000;
      owed <= 9'h000;
      vco_tick <= 1'b0;
    end else begin
      vco_tick <= (owed != 9'h000);
      if (ref_edge) begin
        frac_acc <= frac_sum[15:0];
        owed <= owed + {1'b0, mult_safe} + {8'h00, frac_sum[16]}
                - {8'h00, (owed != 9'h000)};
      end else if (owed != 9'h000) begin
        owed <= owed - 9'h001;
      end
    end
  end
  // ---------------------------------------------
  // output dividers
  // ---------------------------------------------
  wire [3:0] div_clk;
  wire [3:0] div_tick;
  wire [3:0] src_tick;
  wire [31:0] div_set;
  wire [31:0] ph_set;
  assign div_set = {i_div_c, i_div_b, i_div_a, i_div_p};
  assign ph_set = {i_phase_c, i_phase_b, i_phase_a, 8'h00};
  assign src_tick[0] = vco_tick;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_div
      if (g > 0) begin : gen_src
        // chain this divider behind the previous one when asked
        assign src_tick[g] = i_cascade[g-1] ? div_tick[g-1] : vco_tick;
      end
      pcs_out_div u_div (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_tick(src_tick[g]),
        .i_restart(cfg_change),
        .i_div(div_set[g*8+7:g*8]),
        .i_phase(ph_set[g*8+7:g*8]),
        .o_clk(div_clk[g]),
        .o_tick(div_tick[g])
      );
    end
  endgenerate
  // ---------------------------------------------
  // output steering
  // ---------------------------------------------
  // the unused copy is held low so it draws no toggling power
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_primary_clk_out <= 1'b0;
      o_secondary_clk_out_a <= 1'b0;
      o_secondary_clk_out_b <= 1'b0;
      o_secondary_clk_out_c <= 1'b0;
      o_route_clk <= 4'h0;
    end else begin
      o_primary_clk_out <= div_clk[0] & i_to_clk_net[0];
      o_secondary_clk_out_a <= div_clk[1] & i_to_clk_net[1];
      o_secondary_clk_out_b <= div_clk[2] & i_to_clk_net[2];
      o_secondary_clk_out_c <= div_clk[3] & i_to_clk_net[3];
      o_route_clk <= div_clk & ~i_to_clk_net;
    end
  end
  // ---------------------------------------------
  // lock detector
  // ---------------------------------------------
  // feedback edges are counted against reference edges over a window;
  // lock needs a run of good windows, one bad window drops it
  reg [7:0] ref_cnt; // reference edges in window
  reg [7:0] fb_cnt; // feedback edges in window
  reg [7:0] good_cnt; // consecutive good windows
  wire win_end;
  wire win_good;
  wire [7:0] diff;
  assign win_end = ref_edge & (ref_cnt == `PCS_LOCK_CNT);
  assign diff = (fb_cnt > ref_cnt) ? (fb_cnt - ref_cnt) : (ref_cnt - fb_cnt);
  assign win_good = (diff <= `PCS_LOCK_TOL);
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ref_cnt <= 8'h00;
      fb_cnt <= 8'h00;
      good_cnt <= 8'h00;
      o_lock <= 1'b0;
    end else if (cfg_change) begin
      ref_cnt <= 8'h00;
      fb_cnt <= 8'h00;
      good_cnt <= 8'h00;
      o_lock <= 1'b0;
    end else if (win_end) begin
      ref_cnt <= 8'h00;
      fb_cnt <= {7'h00, fb_edge};
      if (win_good) begin
        // saturate the run counter
        if (good_cnt != `PCS_LOCK_TOL) begin
          good_cnt <= good_cnt + 8'h01;
        end
        o_lock <= (good_cnt == `PCS_LOCK_TOL);
      end else begin
        good_cnt <= 8'h00;
        o_lock <= 1'b0;
      end
    end else begin
      ref_cnt <= ref_cnt + {7'h00, ref_edge};
      // saturate so a runaway feedback cannot wrap to a good count
      if (fb_edge && fb_cnt != 8'hff) begin
        fb_cnt <= fb_cnt + 8'h01;
      end
    end
  end
endmodule

/* inc/pcs_map.vh */
// constants for the clock synthesizer control block
`ifndef PCS_MAP_VH
`define PCS_MAP_VH
// ---------------------------------------------
// field widths
// ---------------------------------------------
`define PCS_FRAC_W 16
`define PCS_MULT_W 8
`define PCS_DIV_W 8
`define PCS_PH_W 8
`define PCS_ACC_W 17
// ---------------------------------------------
// divider limits and reset values
// ---------------------------------------------
`define PCS_DIV_MIN 8'h01
`define PCS_DIV_MAX 8'h80
`define PCS_DIV_ONE 8'h01
`define PCS_MULT_RST 8'h01
// ---------------------------------------------
// lock detector
// ---------------------------------------------
`define PCS_LOCK_W 8
`define PCS_LOCK_CNT 8'h40
`define PCS_LOCK_TOL 8'h02
`endif

/* logic/pcs_out_div.v */
// one output divider with phase offset
`timescale 1ns/1ps
module pcs_out_div (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // control
  input wire i_tick,
  input wire i_restart,
  input wire [7:0] i_div,
  input wire [7:0] i_phase,
  // output
  output reg o_clk,
  output reg o_tick
);
`include "pcs_map.vh"
  // ---------------------------------------------
  // divider counter
  // ---------------------------------------------
  reg [7:0] count; // ticks counted so far in this period
  wire [7:0] div_safe; // clamped to the legal range
  wire [7:0] half; // high phase length
  assign div_safe = (i_div < `PCS_DIV_MIN) ? `PCS_DIV_MIN :
                    (i_div > `PCS_DIV_MAX) ? `PCS_DIV_MAX : i_div;
  assign half = {1'b0, div_safe[7:1]};
  // counter loads the phase offset on restart, so outputs skew vs primary
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count <= 8'h00;
      o_clk <= 1'b0;
      o_tick <= 1'b0;
    end else if (i_restart) begin
      count <= i_phase;
      o_clk <= 1'b0;
      o_tick <= 1'b0;
    end else if (i_tick) begin
      // one period is div_safe input ticks
      if (count >= div_safe - `PCS_DIV_ONE) begin
        count <= 8'h00;
        o_tick <= 1'b1;
      end else begin
        count <= count + `PCS_DIV_ONE;
        o_tick <= 1'b0;
      end
      // divide by one passes the tick train as the clock
      o_clk <= (div_safe == `PCS_DIV_ONE) ? 1'b1 : (count < half);
    end else begin
      o_tick <= 1'b0;
      if (div_safe == `PCS_DIV_ONE) begin
        o_clk <= 1'b0;
      end
    end
  end
endmodule

/* sim/pcs_ref_src.sv */
// reference oscillator and feedback return path model
`timescale 1ns/1ps
module pcs_ref_src (
  // control
  input wire i_fb_bad,
  // clocks
  output reg o_ref,
  output wire o_fb
);
  // free-running, phase unrelated to the system clock
  initial o_ref = 1'b0;
  always #50.3 o_ref = ~o_ref;
  // a broken feedback path stands low
  assign #3 o_fb = o_ref & !i_fb_bad;
endmodule

/* sim/pcs_synth_checker.sv */
// assertions on the synthesizer control ports
`timescale 1ns/1ps
module pcs_synth_checker (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // settings and outputs
  input wire [7:0] i_mult_int,
  input wire [7:0] i_div_p,
  input wire [3:0] i_to_clk_net,
  input wire o_primary_clk_out,
  input wire [3:0] o_route_clk,
  input wire o_lock
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // cycles since i_mult_int or i_div_p moved; three lock windows take far longer
  reg [15:0] prev;
  reg [8:0] quiet;
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev <= 16'h0000;
      quiet <= 9'h000;
    end else begin
      prev <= {i_mult_int, i_div_p};
      quiet <= (prev != {i_mult_int, i_div_p}) ? 9'h000 : quiet + {8'h00, ~&quiet};
    end
  end
  sequence s_chg; prev != {i_mult_int, i_div_p}; endsequence
  sequence s_low; !o_lock [*8]; endsequence
  property p_rst; $rose(i_resetn) |-> !o_lock && o_route_clk == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("dirty reset");
  property p_mul; i_mult_int != $past(i_mult_int) |=> !o_lock; endproperty
  a_mul: assert property (p_mul) else $error("lock kept");
  property p_div; i_div_p != $past(i_div_p) |=> !o_lock; endproperty
  a_div: assert property (p_div) else $error("lock kept");
  property p_hold; s_chg |=> s_low; endproperty
  a_hold: assert property (p_hold) else $error("lock early");
  // three windows of 65 reference edges, two clocks apart at best, cannot pass sooner
  property p_wait; $rose(o_lock) |-> quiet > 9'h17f; endproperty
  a_wait: assert property (p_wait) else $error("lock early");
  property p_net; i_to_clk_net[0] [*3] |-> !o_route_clk[0]; endproperty
  a_net: assert property (p_net) else $error("route copy on");
  property p_rt; !i_to_clk_net[0] [*3] |-> !o_primary_clk_out; endproperty
  a_rt: assert property (p_rt) else $error("net copy on");
  property p_net1; i_to_clk_net[1] [*3] |-> !o_route_clk[1]; endproperty
  a_net1: assert property (p_net1) else $error("route copy on");
endmodule
bind pcs_synth_ctrl pcs_synth_checker u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_mult_int(i_mult_int), .i_div_p(i_div_p), .i_to_clk_net(i_to_clk_net),
  .o_primary_clk_out(o_primary_clk_out), .o_route_clk(o_route_clk), .o_lock(o_lock));

/* sim/test_pcs_synth_ctrl.sv */
// self-checking bench for the synthesizer control block
`timescale 1ns/1ps
module test_pcs_synth_ctrl;
  reg i_clk = 1'b0;
  reg i_resetn = 1'b0;
  reg sr = 1'b0, sf = 1'b0, bad = 1'b0, lp, la, lb, lc, lr, sp, sa, sb, sc;
  reg [7:0] mu = 8'h05, dp = 8'h01, da = 8'h02;
  reg [15:0] fr = 16'h0000;
  reg [2:0] cs = 3'h0;
  reg [3:0] net = 4'h0;
  wire rc, fc, op, oa, ob, oc, lk;
  wire [3:0] rt;
  integer seed = 80851, n_mismatch = 0, check_count = 0;
  integer k, t, e, wp, hp, wa, np, tk, ep, ea;
  integer wb, wc, ho, zq, eb, ec;
  always #5 i_clk = ~i_clk;
  pcs_ref_src u_src (.i_fb_bad(bad), .o_ref(rc), .o_fb(fc));
  // unselected sources stand still, so a wrong pick starves the loop
  pcs_synth_ctrl u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ref_clk_pin(rc & !sr),
    .i_ref_clk_route(rc & sr), .i_fb_clk_pin(fc & sf), .i_fb_clk_route(fc & !sf),
    .i_ref_sel_route(sr), .i_fb_sel_pin(sf), .i_mult_int(mu), .i_mult_frac(fr),
    .i_div_p(dp), .i_div_a(da), .i_div_b(dp), .i_div_c(da), .i_cascade(cs),
    .i_phase_a(fr[7:0]), .i_phase_b(da), .i_phase_c(dp), .i_to_clk_net(net),
    .o_primary_clk_out(op), .o_secondary_clk_out_a(oa), .o_secondary_clk_out_b(ob),
    .o_secondary_clk_out_c(oc), .o_route_clk(rt), .o_lock(lk));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %0t: got %0d want %0d", $time, seen, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // bounded wait for a lock level; running out counts as a mismatch
  task wait_lock(input v);
    begin
      for (t = 0; lk !== v && t < 6000; t = t + 1)
        @(negedge i_clk);
      if (lk !== v) begin
        n_mismatch = n_mismatch + 1;
        conclude;
      end
    end
  endtask
  // window edges are fuzzy, so counts within d of the model pass
  function integer near(input integer s, input integer x, input integer d);
    near = (s - x <= d && x - s <= d) ? x : s;
  endfunction
  initial begin
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    i_resetn = 1'b1;
    // the last pass runs equal dividers from one source, so only the phase preload differs
    for (k = 0; k < 7; k = k + 1) begin
      @(negedge i_clk);
      mu = (k == 6) ? 8'h01 : 5 - k;
      dp = (k == 1) ? 8'h80 : (k == 2) ? 8'hc8 : (k == 4) ? 8'h01 : (k == 6) ? 8'h08 :
        2 + {$random(seed)} % 9;
      da = (k == 6) ? 8'h08 : 2 + {$random(seed)} % 7;
      fr = (k == 6) ? 16'h0003 : k[0] ? $random(seed) : 0;
      t = $random(seed);
      {sr, sf} = t[8:7];
      cs = (k == 6) ? 3'h0 : t[6:4];
      net = (k == 6) ? 4'hf : {t[3:1], k[1]};
      @(negedge i_clk);
      check(lk, 0);
      wait_lock(1);
      {wp, hp, wa, wb, wc, ho, zq, e} = 0;
      {lp, la, lb, lc, lr} = 5'h1f;
      for (t = 0; e < 128 && t < 4000; t = t + 1) begin
        @(negedge i_clk);
        sp = net[0] ? op : rt[0];
        sa = net[1] ? oa : rt[1];
        sb = net[2] ? ob : rt[2];
        sc = net[3] ? oc : rt[3];
        // the copy that is not selected must never rise
        zq = zq + ((net & rt) != 4'h0) + (op & !net[0]) + (oa & !net[1]) + (ob & !net[2]) +
          (oc & !net[3]);
        wp = wp + (sp & !lp);
        hp = hp + sp;
        ho = ho + (sp & sa);
        wa = wa + (sa & !la);
        wb = wb + (sb & !lb);
        wc = wc + (sc & !lc);
        e = e + (rc & !lr);
        {lp, la, lb, lc, lr} = {sp, sa, sb, sc, rc};
      end
      // a stalled reference counts as a failure, not a hang
      if (e < 128) begin
        n_mismatch = n_mismatch + 1;
        conclude;
      end
      // model: ticks from multiplier and fraction, then each divider in its chain
      np = (dp > 8'h80) ? 128 : dp;
      tk = (128 * (((mu == 0) + mu) * 65536 + fr)) / 65536;
      ep = (np == 1) ? tk : tk / np;
      ea = (cs[0] ? tk / np : tk) / da;
      eb = (cs[1] ? ea : tk) / np;
      ec = (cs[2] ? eb : tk) / da;
      check(near((np == 1) ? hp : wp, ep, (np == 1) ? 8 : 2), ep);
      check(near(wa, ea, 2), ea);
      check(near(wb, eb, 2), eb);
      check(near(wc, ec, 2), ec);
      check(zq, 0);
      // a preloaded three ticks ahead overlaps the primary high phase one tick in four
      if (k == 6) begin
        check(near(4 * ho, hp, hp / 4), hp);
      end
      $display("test %0d done", k);
    end
    bad = 1'b1;
    wait_lock(0);
    bad = 1'b0;
    wait_lock(1);
    i_resetn = 1'b0;
    @(negedge i_clk);
    check({lk, rt}, 0);
    $display("test reset done");
    conclude;
  end
endmodule
